// >>> design/rx_bitsync_pattern_strength.v
`timescale 1ns/1ps
`default_nettype none
`include "rx_backend_regs.vh"

module rx_bitsync_pattern_strength #(
  parameter integer PERIOD_STEP_CYC = `CLK_HZ / 1000000 * `PERIOD_STEP_US
) (
  input wire aclk, // system clock
  input wire aresetn, // sync reset, active low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire raw_data, // raw demodulator output, async
  input wire [1:0] live_strength, // comparator bank, async
  output reg data_out, // recovered serial data
  output reg recovered_bit_clock, // recovered clock, line one
  output reg irq_line_zero // match or strength interrupt
);

  // ==========================================================
  // registers
  reg [31:0] ctrl; // control bits
  reg [31:0] rate; // divider and ratio
  reg [31:0] pattern; // reference word
  reg [1:0] strength_level; // host-visible latched level
  reg strength_detect_flag; // sticky threshold flag
  reg [1:0] live_level; // periodic live level
  reg match; // correlator output
  reg locked; // preamble lock seen

  wire synchronizer_disable = ctrl[`B_SYNC_DIS];
  wire fixed_rate_bus_mode = ctrl[`B_FIXED];
  wire oversample_override = ctrl[`B_OVR];
  wire correlator_enable = ctrl[`B_CORR_EN];
  wire strength_enable = ctrl[`B_STR_EN];
  wire strength_range_select = ctrl[`B_RANGE];
  wire strength_irq_enable = ctrl[`B_SIRQ_EN];
  wire [1:0] match_length = ctrl[`F_LEN];
  wire [1:0] match_error_tolerance = ctrl[`F_TOL];
  wire [1:0] line_zero_source_select = ctrl[`F_LSEL];
  wire [1:0] strength_threshold = ctrl[`F_THR];
  wire [2:0] deviation_band = ctrl[`F_DEV];
  wire [6:0] bit_rate_divider = rate[`F_DIV];
  wire [7:0] oversample_ratio = rate[`F_OSR];

  // ==========================================================
  // input synchronisers: two flops before any use
  reg [1:0] raw_sync; // raw data sync chain
  reg [1:0] str_meta; // level first stage
  reg [1:0] str_sync; // level second stage
  reg [1:0] str_last; // level one clock back
  always @(posedge aclk) begin
    if (!aresetn) begin
      raw_sync <= 2'h0;
      str_meta <= 2'h0;
      str_sync <= 2'h0;
      str_last <= 2'h0;
    end else begin
      raw_sync <= {raw_sync[0], raw_data};
      str_meta <= live_strength;
      str_sync <= str_meta;
      str_last <= str_sync;
    end
  end
  wire raw_s = raw_sync[1];

  // ==========================================================
  // oversample tick from a 32-bit phase accumulator: a fixed
  // step is added each clock and the carry out is the tick, so
  // the average tick rate is exact although the clock is no
  // whole multiple of it; a tick jitters by one clock at most.
  // the tick rate is base*32/(div+1) whatever the ratio: the
  // ratio only decides how many ticks make one bit, which is
  // how the override scales the bit rate by 32/(ratio+1).
  // limitation: the ratio must stay at 15 or more, or too few
  // ticks fall in a bit for the filter and the phase count
  localparam [7:0] OSR_DEF_LAST = `DEF_OSR - 1; // last phase, default
  localparam [63:0] TICK_NORM_HZ = `BASE_RATE_HZ * `DEF_OSR; // div 0
  localparam [63:0] TICK_FIXED_HZ = `FIXED_RATE_HZ * `DEF_OSR; // bus
  localparam [63:0] STEP_NORM = (TICK_NORM_HZ << 32) / `CLK_HZ;
  localparam [63:0] STEP_FIXED = (TICK_FIXED_HZ << 32) / `CLK_HZ;
  wire [7:0] osr_eff = oversample_override ? oversample_ratio
                                           : OSR_DEF_LAST;
  // one divider shared by every rate but the fixed bus rate; truncation costs less
  // than one part per million of rate
  wire [63:0] step_div = STEP_NORM /
                         ({57'h0, bit_rate_divider} + 64'h1);
  wire [31:0] step = fixed_rate_bus_mode ? STEP_FIXED[31:0]
                                         : step_div[31:0];
  reg [31:0] phase_acc; // fractional accumulator
  reg os_tick; // one oversample instant
  wire [32:0] acc_sum = {1'b0, phase_acc} + {1'b0, step};
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_acc <= 32'h0;
      os_tick <= 1'b0;
    end else begin
      // the carry out of the sum is the tick
      phase_acc <= acc_sum[31:0];
      os_tick <= acc_sum[32];
    end
  end

  // ==========================================================
  // majority deglitch filter over three samples
  reg [2:0] hist; // last three samples
  reg clean; // filtered level
  always @(posedge aclk) begin
    if (!aresetn) begin
      hist <= 3'h0;
      clean <= 1'b0;
    end else if (os_tick) begin
      hist <= {hist[1:0], raw_s};
      clean <= (hist[0] & hist[1]) | (hist[1] & raw_s) |
               (hist[0] & raw_s);
    end
  end

  // ==========================================================
  // bit phase counter; realigned on each data edge so the
  // rising clock edge lands mid-bit. with equal rates no edge
  // is needed, so equal-bit runs are unlimited
  reg [7:0] ph; // oversample phase in bit
  reg prev_clean; // edge detector
  reg [4:0] lock_cnt; // preamble transition count
  reg bit_rise; // recovered clock rising this cycle
  wire edge_seen = clean ^ prev_clean;
  wire [7:0] half = {1'b0, osr_eff[7:1]};
  always @(posedge aclk) begin
    if (!aresetn) begin
      ph <= 8'h0;
      prev_clean <= 1'b0;
      lock_cnt <= 5'h0;
      locked <= 1'b0;
      bit_rise <= 1'b0;
    end else begin
      bit_rise <= 1'b0;
      if (synchronizer_disable) begin
        locked <= 1'b0;
        lock_cnt <= 5'h0;
      end else if (os_tick) begin
        prev_clean <= clean;
        if (edge_seen) begin
          ph <= 8'h0;
          if (lock_cnt != `LOCK_BITS - 1)
            lock_cnt <= lock_cnt + 5'h1;
          else
            locked <= 1'b1;
        end else if (ph == osr_eff) begin
          ph <= 8'h0;
        end else begin
          ph <= ph + 8'h1;
        end
        if (ph == half && !edge_seen)
          bit_rise <= 1'b1;
      end
    end
  end

  // ==========================================================
  // outputs: recovered clock high in second half of bit; data
  // moves at phase one, far from the rising edge the host uses
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_out <= 1'b0;
      recovered_bit_clock <= 1'b0;
    end else if (synchronizer_disable) begin
      data_out <= raw_s;
      recovered_bit_clock <= 1'b0;
    end else begin
      // data stable before clock rise, valid at rise
      if (os_tick && ph == 8'h1)
        data_out <= clean;
      if (bit_rise)
        recovered_bit_clock <= 1'b1;
      else if (os_tick && ph == 8'h0)
        recovered_bit_clock <= 1'b0;
    end
  end

  // ==========================================================
  // correlator: 8/16/24/32 bits, 0..3 errors tolerated
  reg [31:0] shreg; // received bits, newest in bit 0
  // compare the word as it stands once this bit is in, so a
  // match shows at the very clock rise that completes it
  wire [31:0] next_shreg = {shreg[30:0], clean}; // shifted word
  reg [31:0] mask; // compared bits
  reg [5:0] errs; // mismatch count
  integer i;
  always @* begin
    mask = 32'hFFFF_FFFF >> {match_length == 2'h0 ? 5'd24 :
           match_length == 2'h1 ? 5'd16 :
           match_length == 2'h2 ? 5'd8 : 5'd0};
    errs = 6'h0;
    for (i = 0; i < 32; i = i + 1)
      errs = errs + {5'h0, mask[i] & (next_shreg[i] ^ pattern[i])};
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      shreg <= 32'h0;
      match <= 1'b0;
    end else if (synchronizer_disable || !correlator_enable) begin
      match <= 1'b0;
    end else if (bit_rise) begin
      shreg <= next_shreg;
      match <= errs <= {4'h0, match_error_tolerance};
    end
  end

  // ==========================================================
  // strength monitor: period 100..500 us by deviation band
  reg [31:0] per_cnt; // period counter
  wire [2:0] band = (deviation_band > 3'h4) ? 3'h4 : deviation_band;
  wire [31:0] period_cyc = PERIOD_STEP_CYC * ({29'h0, band} + 32'h1);
  wire strength_rd;
  always @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt <= 32'h0;
      live_level <= 2'h0;
    end else if (!strength_enable) begin
      per_cnt <= 32'h0;
    end else if (per_cnt >= period_cyc - 32'h1) begin
      // both level bits may move at once; wait out the clock in
      // which the two synchronised bits could disagree
      if (str_sync == str_last) begin
        per_cnt <= 32'h0;
        // range select affects analog thresholds; code passes
        live_level <= str_sync;
      end
    end else begin
      per_cnt <= per_cnt + 32'h1;
    end
  end

  // ==========================================================
  // axi-lite slave, one write and one read at a time
  reg aw_got, w_got; // halves of a write
  reg [7:0] aw_addr; // captured write address
  reg [31:0] w_data; // captured write data
  reg [3:0] w_strb; // captured strobes
  wire do_write = aw_got && w_got && !s_axi_bvalid;
  wire clr_detect = do_write && aw_addr == `OFF_STATUS &&
                    w_strb[0] && w_data[`B_DETECT];
  wire set_detect = strength_enable && strength_irq_enable &&
                    live_level >= strength_threshold;

  function [31:0] merge;
    input [31:0] old, nw;
    input [3:0] be;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      ctrl <= `CTRL_RST;
      rate <= `RATE_RST;
      pattern <= 32'h0;
      strength_detect_flag <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `AXI_OKAY;
        case (aw_addr)
          `OFF_CTRL: ctrl <= merge(ctrl, w_data, w_strb);
          `OFF_RATE: rate <= merge(rate, w_data, w_strb);
          `OFF_PATTERN: pattern <= merge(pattern, w_data, w_strb);
          `OFF_STRENGTH, `OFF_STATUS: ;
          default: s_axi_bresp <= `AXI_DECERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // set wins over a clear in the same cycle
      if (set_detect)
        strength_detect_flag <= 1'b1;
      else if (clr_detect)
        strength_detect_flag <= 1'b0;
    end
  end

  // read channel; a read of the strength register latches level while strength enable is set
  assign strength_rd = s_axi_arvalid && s_axi_arready &&
                       s_axi_araddr == `OFF_STRENGTH;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AXI_OKAY;
      strength_level <= 2'h0;
    end else begin
      if (strength_rd && strength_enable)
        strength_level <= live_level;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AXI_OKAY;
        case (s_axi_araddr)
          `OFF_CTRL: s_axi_rdata <= ctrl;
          `OFF_RATE: s_axi_rdata <= rate;
          `OFF_PATTERN: s_axi_rdata <= pattern;
          `OFF_STRENGTH: s_axi_rdata <= {30'h0, (strength_enable ?
                                         live_level : strength_level)};
          `OFF_STATUS: s_axi_rdata <= {27'h0, locked, match,
                          strength_detect_flag, strength_level};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `AXI_DECERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // line zero: strength irq when select 01, else match
  always @(posedge aclk) begin
    if (!aresetn)
      irq_line_zero <= 1'b0;
    else if (line_zero_source_select == `LSEL_STRENGTH)
      irq_line_zero <= strength_detect_flag;
    else
      irq_line_zero <= match;
  end

endmodule
`default_nettype wire

// >>> design/rx_backend_regs.vh
// Contract
// - deglitch raw data, recover bit clock on line one
// - clock rising edge centred, tracked on transitions
// - long equal-bit runs tolerated, drift limited
// - enabled at reset; disable passes raw, clock low
// - rate is 152.34e3 over divider plus one
// - fixed bus mode forces 32.768 kbit/s
// - oversampling 32, override scales by ratio
// - correlator compares stream with 32-bit reference
// - match level updates on recovered clock rises
// - length and tolerance fields set comparison
// - correlator idle while synchronizer disabled
// - strength enable starts 2-bit level monitor
// - level codes 00 to 11 by threshold band
// - range select picks threshold set
// - live level periodic, latched on host read
// - measure period follows deviation band
// - detect flag when live level reaches threshold; code also needs strength irq enable set
// - line zero carries strength irq when select 01
// - write one clears flag, detection resumes
`ifndef RX_BACKEND_REGS_VH
`define RX_BACKEND_REGS_VH

// ==========================================================
// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_RATE 8'h04
`define OFF_PATTERN 8'h08
`define OFF_STRENGTH 8'h0C
`define OFF_STATUS 8'h10

// ==========================================================
// control register fields
`define B_SYNC_DIS 0
`define B_FIXED 1
`define B_OVR 2
`define B_CORR_EN 3
`define B_STR_EN 4
`define B_RANGE 5
`define B_SIRQ_EN 6
`define F_LEN 9:8
`define F_TOL 11:10
`define F_LSEL 13:12
`define F_THR 15:14
`define F_DEV 18:16
`define CTRL_RST 32'h0000_0000

// rate register: divider and oversample ratio
`define F_DIV 6:0
`define F_OSR 15:8
`define RATE_RST 32'h0000_1F00

// status register
`define F_LEVEL 1:0
`define B_DETECT 2
`define B_MATCH 3
`define B_LOCK 4

// ==========================================================
// timing: base rate figure in Hz, clock in Hz
`define BASE_RATE_HZ 152340
`define FIXED_RATE_HZ 32768
`define DEF_OSR 32
`define CLK_HZ 125000000
`define LOCK_BITS 24
`define PERIOD_STEP_US 100
`define LSEL_STRENGTH 2'h1
`define AXI_OKAY 2'h0
`define AXI_DECERR 2'h3

`endif

// >>> testbench/rx_bitsync_pattern_strength_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker, sees only the top module pins
module rx_port_chk (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic recovered_bit_clock // recovered clock
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken on one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_aw_closed: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("write address still open");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid &&
    !s_axi_arready) else $error("read answer missing");
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_unmapped_err: assert property (s_rd_taken ##0 s_axi_araddr > 8'h10
    |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (s_rd_taken ##0 s_axi_araddr <= 8'h10
    ##0 s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  // recovered clock phases last far longer than a few system clocks
  a_clk_high_run: assert property ($rose(recovered_bit_clock) |=>
    recovered_bit_clock [*8]) else $error("clock high phase short");
  a_clk_low_run: assert property ($fell(recovered_bit_clock) |=>
    !recovered_bit_clock [*8]) else $error("clock low phase short");
endmodule
bind rx_bitsync_pattern_strength rx_port_chk u_chk (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .recovered_bit_clock(recovered_bit_clock));
`default_nettype wire

// >>> testbench/rx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host side: samples recovered data on clock rises
module rx_host_model (
  input wire logic aclk, // system clock
  input wire logic clr, // forget what was seen
  input wire logic bit_clock, // recovered clock
  input wire logic data_in, // recovered data
  input wire logic [31:0] expect_word, // word to look for
  output logic seen // word arrived in order
);
  logic last = 1'b0; // clock level one edge back
  logic [31:0] window = 32'h0; // last 32 sampled bits
  initial seen = 1'b0;
  // rise found by edge detect, data taken only there
  always @(posedge aclk) begin
    last <= bit_clock;
    if (clr) begin
      seen <= 1'b0;
    end else if (bit_clock && !last) begin
      window <= {window[30:0], data_in};
      if ({window[30:0], data_in} == expect_word) begin
        seen <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, raw_data;
  logic awready, wready, bvalid, arready, rvalid, data_out, bit_clk;
  logic irq0, seen, hit, clr;
  logic [7:0] awaddr, araddr; // bus addresses
  logic [31:0] wdata, rdata, rd_val, word; // bus data, payload
  logic [3:0] wstrb; // byte enables
  logic [1:0] live_strength, bresp, rresp, rd_resp, wr_resp, lv;
  integer failures = 0, total_checks = 0, i;
  // ==========================================================
  // design, host model
  rx_bitsync_pattern_strength #(.PERIOD_STEP_CYC(20))
    u_rx_bitsync_pattern_strength (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .raw_data(raw_data),
    .live_strength(live_strength), .data_out(data_out),
    .recovered_bit_clock(bit_clk), .irq_line_zero(irq0));
  rx_host_model u_rx_host_model (.aclk(aclk), .clr(clr),
    .bit_clock(bit_clk), .data_in(data_out), .expect_word(word),
    .seen(seen));
  // ==========================================================
  // clock, watchdog, match catcher
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    #600_000;
    failures++;
    stop_test;
  end
  // match pulses are short, so keep a sticky copy
  always @(posedge aclk) hit <= clr ? 1'b0 : (hit | irq0);
  // ==========================================================
  // shared tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      total_checks++;
      if (s !== e) begin
        failures++;
        $display("BAD %0t seen %h want %h", $time, s, e);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge aclk);
  endtask
  // both write halves offered together, each dropped when taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    integer n;
    begin
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        n++;
      end while (!bvalid && n < 100);
      wr_resp = bresp;
      bready <= 1'b0;
      if (n >= 100) failures++;
    end
  endtask
  task rd(input logic [7:0] a);
    integer n;
    begin
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        n++;
      end while (!rvalid && n < 100);
      rd_val = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
      if (n >= 100) failures++;
    end
  endtask
  // one bit on the air, about 821 clocks at 152.34 kbit/s
  task send(input logic b);
    begin
      raw_data <= b;
      cyc(821);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(94));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, clr} = 7'h0;
    {awaddr, araddr, wdata, wstrb, raw_data, live_strength} = 55'h0;
    word = 32'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00);
    chk(rd_val, 32'h0000_0000);
    rd(8'h04);
    chk(rd_val, 32'h0000_1F00);
    wr(8'h04, 32'hFFFF_FF01, 4'h1);
    wr(8'h04, 32'h0000_0F00, 4'h2);
    rd(8'h04);
    chk(rd_val, 32'h0000_0F01);
    rd(8'h20);
    chk({30'h0, rd_resp}, 32'h3);
    chk(rd_val, 32'h0);
    wr(8'h24, 32'hFFFF_FFFF, 4'hF);
    chk({30'h0, wr_resp}, 32'h3);
    $display("-- registers done");
    // synchronizer off: raw level straight through, clock parked
    // park only just after a fall, so no high phase is cut short
    @(negedge bit_clk);
    wr(8'h00, 32'h0000_0009, 4'hF);
    for (i = 0; i < 8; i++) begin
      raw_data <= 1'($urandom);
      cyc(6);
      chk({31'h0, data_out}, {31'h0, raw_data});
      chk({31'h0, bit_clk}, 32'h0);
      chk({31'h0, irq0}, 32'h0);
    end
    $display("-- bypass done");
    // preamble then a random word, reference one bit off
    word = $urandom;
    wr(8'h08, word ^ 32'h0000_0100, 4'hF);
    wr(8'h00, 32'h0000_070C, 4'hF);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    for (i = 0; i < 24; i++) send(i[0]);
    for (i = 31; i >= 0; i--) send(word[i]);
    for (i = 0; i < 4; i++) send(i[0]);
    chk({31'h0, seen}, 32'h1);
    chk({31'h0, hit}, 32'h1);
    rd(8'h10);
    chk({31'h0, rd_val[4]}, 32'h1);
    $display("-- link done");
    // strength monitor, threshold 10, line zero carries it
    wr(8'h00, 32'h0000_9050, 4'hF);
    for (i = 0; i < 5; i++) begin
      lv = (i == 0) ? 2'h2 : 2'($urandom);
      live_strength <= lv;
      cyc(100);
      rd(8'h0C);
      chk(rd_val & 32'h3, {30'h0, lv});
      rd(8'h10);
      chk({31'h0, rd_val[2]}, {31'h0, lv >= 2'h2});
      chk(rd_val & 32'h3, {30'h0, lv});
      chk({31'h0, irq0}, {31'h0, lv >= 2'h2});
      live_strength <= 2'h0;
      cyc(100);
      wr(8'h10, 32'h0000_0004, 4'hF);
      cyc(4);
      chk({31'h0, irq0}, 32'h0);
    end
    $display("-- strength done");
    stop_test;
  end
endmodule
`default_nettype wire
